// file: logic/dwpr_controller.sv
// host controller driving a 64k x 1 multiplexed-address dynamic ram
`timescale 1ns/1ps
// What this block does
// - early write asserts write on the same clock as column strobe
// - hold strobes for lead times after write
// - late write accepted within row-active limit
// - shared bus uses early writes only; the block still issues late writes for read-modify-write and read-while-write
// - read-modify-write asserts write after access time
// - read-while-write waits row/column-to-write delay
// - page mode cycles column strobe, row held
// - row strobe never active beyond 10 us
// - page starts normal, then short column cycles
// - page accesses mix freely, each timed normally
// - refresh all 128 rows every 2 ms
// - column strobe stays high during refresh
// - refresh pin low under 2 us, auto
// - auto refresh distributed, one row per interval
// - refresh ignores top row address bit
// - write high across whole read column
// - 100 us pause then eight wake cycles
module dwpr_controller import dwpr_pkg::*; #(
  parameter int POWERUP_CYC = POWERUP_PAUSE_CYC, // shorten in simulation
  parameter int INTERVAL_CYC = REFRESH_INTERVAL_CYC, // shorten in simulation
  parameter bit USE_REFRESH_PIN = 1'b0 // refresh by pin instead of row-only cycles
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic req_valid, // access request
  output logic req_ready, // request taken this clock
  input wire logic [1:0] req_op, // access kind
  input wire logic [ROW_BITS-1:0] req_row, // row address
  input wire logic [COL_BITS-1:0] req_col, // column address
  input wire logic req_data, // write data
  input wire logic req_invert, // rmw: store inverse of read bit
  input wire logic sleep_req, // hold refresh pin low for self refresh
  output logic rsp_valid, // read data valid, one clock
  output logic rsp_data, // read data
  output logic ready, // initialisation done
  output logic row_strobe_n, // row address strobe
  output logic column_strobe_n, // column address strobe
  output logic write_strobe_n, // write strobe
  output logic refresh_request_n, // refresh pin
  output logic [ADDR_BITS-1:0] mem_addr, // multiplexed address
  output logic mem_din, // data to device
  input wire logic mem_dout // data from device, floating when idle
);
  typedef struct packed {
    dwpr_state_type state;
    logic [TIMER_BITS-1:0] timer;
    logic [TIMER_BITS-1:0] row_timer;
    logic [3:0] wake;
    logic [1:0] op;
    logic [ROW_BITS-1:0] row;
    logic [COL_BITS-1:0] col;
    logic data;
    logic invert;
    logic [6:0] refresh_row;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic ref_n;
    logic [ADDR_BITS-1:0] addr;
    logic din;
    logic rsp_valid;
    logic rsp_data;
    logic ready;
    logic page_more;
  } dwpr_ctrl_type;
  dwpr_ctrl_type st_reg;
  dwpr_ctrl_type st_next;

  logic [1:0] rst_sync;
  logic rst_sync_n;
  logic dout_meta;
  logic dout_sync;
  logic refresh_due;
  logic refresh_taken;
  logic take;
  logic same_row;
  logic row_time_left;

  initial begin
    if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << TIMER_BITS)) begin
      $error("power-up pause out of range");
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  // the device pin is asynchronous to our clock
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end else begin
      dout_meta <= mem_dout;
      dout_sync <= dout_meta;
    end
  end

  dwpr_refresh_timer #(
    .INTERVAL_CYC(INTERVAL_CYC)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .taken(refresh_taken),
    .due(refresh_due)
  );

  // stay on the open row only if one more column cycle fits inside the row-active limit
  assign same_row = st_reg.page_more && req_valid && !refresh_due && req_row == st_reg.row;
  assign row_time_left = st_reg.row_timer <
    TIMER_BITS'(ROW_ACTIVE_MAX_CYC - ROW_PRECHARGE_CYC - 4 * ROW_ACCESS_CYC);
  assign take = st_reg.state == ST_IDLE && st_reg.ready && req_valid && !refresh_due && !sleep_req;
  assign refresh_taken = st_reg.state == ST_IDLE && st_reg.ready && refresh_due && !sleep_req;
  assign req_ready = take || (st_reg.state == ST_COL_PRE && st_reg.timer == '0 && same_row && row_time_left);

  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    if (st_reg.timer != '0) begin
      st_next.timer = st_reg.timer - 1'b1;
    end
    if (!st_reg.ras_n) begin
      st_next.row_timer = st_reg.row_timer + 1'b1;
    end else begin
      st_next.row_timer = '0;
    end
    case (st_reg.state)
      ST_POWERUP: begin
        if (st_reg.timer == '0) begin
          st_next.state = ST_WAKE;
          st_next.ras_n = 1'b0;
          st_next.timer = TIMER_BITS'(COLUMN_ACTIVE_CYC * 2);
        end
      end
      ST_WAKE: begin
        if (st_reg.timer == '0) begin
          if (!st_reg.ras_n) begin
            st_next.ras_n = 1'b1;
            st_next.timer = TIMER_BITS'(ROW_PRECHARGE_CYC);
            st_next.wake = st_reg.wake + 1'b1;
          end else if (st_reg.wake == 4'(WAKE_CYCLES)) begin
            st_next.state = ST_IDLE;
            st_next.ready = 1'b1;
          end else begin
            st_next.ras_n = 1'b0;
            st_next.timer = TIMER_BITS'(COLUMN_ACTIVE_CYC * 2);
          end
        end
      end
      ST_IDLE: begin
        st_next.ref_n = !sleep_req;
        if (refresh_taken) begin
          st_next.state = USE_REFRESH_PIN ? ST_PIN_REFRESH : ST_REFRESH;
          if (USE_REFRESH_PIN) begin
            st_next.ref_n = 1'b0;
            st_next.timer = TIMER_BITS'(ROW_ACCESS_CYC);
          end else begin
            st_next.addr = {1'b0, st_reg.refresh_row};
            st_next.timer = 16'h0001;
          end
        end else if (take) begin
          st_next.op = req_op;
          st_next.row = req_row;
          st_next.col = req_col;
          st_next.data = req_data;
          st_next.invert = req_invert;
          st_next.addr = req_row;
          st_next.state = ST_ROW;
          st_next.timer = 16'h0001;
        end
      end
      ST_ROW: begin
        if (st_reg.timer == '0) begin
          st_next.ras_n = 1'b0;
          st_next.state = ST_COL;
          st_next.timer = TIMER_BITS'(ROW_COLUMN_CYC);
        end
      end
      ST_COL: begin
        st_next.addr = st_reg.col;
        if (st_reg.timer == '0 && st_reg.cas_n) begin
          st_next.cas_n = 1'b0;
          st_next.din = st_reg.data;
          if (st_reg.op == OP_EARLY_WRITE) begin
            st_next.we_n = 1'b0;
            st_next.state = ST_HOLD;
            st_next.timer = TIMER_BITS'(COLUMN_LEAD_CYC > COLUMN_ACTIVE_CYC ?
              COLUMN_LEAD_CYC : COLUMN_ACTIVE_CYC);
          end else if (st_reg.op == OP_READ_WHILE_WRITE) begin
            st_next.state = ST_WRITE;
            st_next.timer = TIMER_BITS'(COLUMN_TO_WRITE_CYC);
          end else begin
            st_next.state = ST_WRITE;
            st_next.timer = TIMER_BITS'(COLUMN_ACTIVE_CYC + 2);
          end
        end
      end
      ST_WRITE: begin
        if (st_reg.timer == '0) begin
          // a read waits out the row access time and the two synchroniser stages on the data pin
          if (st_reg.row_timer < TIMER_BITS'(st_reg.op == OP_READ_WHILE_WRITE ?
              ROW_TO_WRITE_CYC : ROW_ACCESS_CYC + 2)) begin
            st_next.state = ST_WRITE;
          end else if (st_reg.op == OP_READ) begin
            st_next.rsp_valid = 1'b1;
            st_next.rsp_data = dout_sync;
            st_next.state = ST_HOLD;
          end else begin
            // late write edge; data in is taken on this falling edge
            st_next.rsp_valid = st_reg.op == OP_READ_MODIFY_WRITE;
            st_next.rsp_data = dout_sync;
            st_next.din = st_reg.op == OP_READ_MODIFY_WRITE ?
              (dout_sync ^ st_reg.invert) : st_reg.data;
            st_next.state = ST_HOLD;
          end
          if (st_next.state == ST_HOLD && st_reg.op != OP_READ) begin
            st_next.we_n = 1'b0;
            st_next.timer = TIMER_BITS'(COLUMN_LEAD_CYC > WRITE_PULSE_CYC ?
              COLUMN_LEAD_CYC : WRITE_PULSE_CYC);
          end
        end
      end
      ST_HOLD: begin
        if (st_reg.timer == '0) begin
          st_next.cas_n = 1'b1;
          st_next.we_n = 1'b1;
          st_next.state = ST_COL_PRE;
          st_next.page_more = 1'b1;
          st_next.timer = TIMER_BITS'(COLUMN_PRECHARGE_CYC);
        end
      end
      ST_COL_PRE: begin
        if (st_reg.timer == '0) begin
          if (same_row && row_time_left) begin
            st_next.op = req_op;
            st_next.col = req_col;
            st_next.data = req_data;
            st_next.invert = req_invert;
            st_next.state = ST_COL;
          end else begin
            st_next.ras_n = 1'b1;
            st_next.page_more = 1'b0;
            st_next.state = ST_ROW_PRE;
            st_next.timer = TIMER_BITS'(ROW_PRECHARGE_CYC);
          end
        end
      end
      ST_REFRESH: begin
        if (st_reg.timer == '0) begin
          if (st_reg.ras_n) begin
            st_next.ras_n = 1'b0;
            st_next.timer = TIMER_BITS'(ROW_ACCESS_CYC);
          end else begin
            st_next.ras_n = 1'b1;
            st_next.refresh_row = st_reg.refresh_row + 1'b1;
            st_next.state = ST_ROW_PRE;
            st_next.timer = TIMER_BITS'(ROW_PRECHARGE_CYC);
          end
        end
      end
      ST_PIN_REFRESH: begin
        if (st_reg.timer == '0) begin
          st_next.ref_n = 1'b1;
          st_next.state = ST_ROW_PRE;
          st_next.timer = TIMER_BITS'(ROW_PRECHARGE_CYC);
        end
      end
      ST_ROW_PRE: begin
        if (st_reg.timer == '0) begin
          st_next.state = ST_IDLE;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= '{state: ST_POWERUP, timer: TIMER_BITS'(POWERUP_CYC), row_timer: '0, wake: '0,
        op: OP_READ, row: '0, col: '0, data: 1'b0, invert: 1'b0, refresh_row: '0,
        ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, addr: '0, din: 1'b0,
        rsp_valid: 1'b0, rsp_data: 1'b0, ready: 1'b0, page_more: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign row_strobe_n = st_reg.ras_n;
  assign column_strobe_n = st_reg.cas_n;
  assign write_strobe_n = st_reg.we_n;
  assign refresh_request_n = st_reg.ref_n;
  assign mem_addr = st_reg.addr;
  assign mem_din = st_reg.din;
  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_data = st_reg.rsp_data;
  assign ready = st_reg.ready;
endmodule : dwpr_controller

// file: logic/dwpr_pkg.sv
// constants for the dram write, page and refresh controller
package dwpr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // documented times in their own units
  localparam int ROW_ACTIVE_MAX_NS = 10000;
  localparam int REFRESH_INTERVAL_NS = 15600;
  localparam int POWERUP_PAUSE_NS = 100000;
  localparam int AUTO_REFRESH_PULSE_MAX_NS = 2000;
  localparam int ROW_LEAD_TIME_NS = 40;
  localparam int COLUMN_LEAD_TIME_NS = 40;
  localparam int ROW_ACCESS_TIME_NS = 120;
  localparam int ROW_PRECHARGE_TIME_NS = 100;
  localparam int COLUMN_PRECHARGE_TIME_NS = 50;
  localparam int ROW_COLUMN_DELAY_NS = 25;
  localparam int COLUMN_ACTIVE_NS = 60;
  localparam int ROW_TO_WRITE_DELAY_NS = 100;
  localparam int COLUMN_TO_WRITE_DELAY_NS = 40;
  localparam int WRITE_PULSE_NS = 25;
  // cycle counts: least times round up, longest round down
  localparam int ROW_ACTIVE_MAX_CYC = ROW_ACTIVE_MAX_NS / CLK_PERIOD_NS;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int POWERUP_PAUSE_CYC = (POWERUP_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTO_REFRESH_PULSE_CYC = AUTO_REFRESH_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int ROW_LEAD_CYC = (ROW_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLUMN_LEAD_CYC = (COLUMN_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ACCESS_CYC = (ROW_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLUMN_PRECHARGE_CYC = (COLUMN_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_COLUMN_CYC = (ROW_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLUMN_ACTIVE_CYC = (COLUMN_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TO_WRITE_CYC = (ROW_TO_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLUMN_TO_WRITE_CYC = (COLUMN_TO_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = 8;
  localparam int REFRESH_ROWS = 128;
  localparam int ROW_BITS = 8;
  localparam int COL_BITS = 8;
  localparam int ADDR_BITS = 8;
  localparam int TIMER_BITS = 16;
  // access kinds on the user command port
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_EARLY_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_MODIFY_WRITE = 2'h2;
  localparam logic [1:0] OP_READ_WHILE_WRITE = 2'h3;
  typedef enum logic [10:0] {
    ST_POWERUP = 11'h001,
    ST_WAKE = 11'h002,
    ST_IDLE = 11'h004,
    ST_ROW = 11'h008,
    ST_COL = 11'h010,
    ST_WRITE = 11'h020,
    ST_HOLD = 11'h040,
    ST_COL_PRE = 11'h080,
    ST_ROW_PRE = 11'h100,
    ST_REFRESH = 11'h200,
    ST_PIN_REFRESH = 11'h400
  } dwpr_state_type;
endpackage : dwpr_pkg

// file: logic/dwpr_refresh_timer.sv
// refresh pacing timer: one request per interval, held until taken
`timescale 1ns/1ps
module dwpr_refresh_timer import dwpr_pkg::*; #(
  parameter int INTERVAL_CYC = REFRESH_INTERVAL_CYC
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_sync_n, // synchronised reset, active low
  input wire logic taken, // refresh cycle started this clock
  output logic due // a row refresh is owed
);
  typedef struct packed {
    logic [TIMER_BITS-1:0] count;
    logic due;
  } dwpr_timer_type;
  dwpr_timer_type st_reg;
  dwpr_timer_type st_next;

  initial begin
    if (INTERVAL_CYC < 2 || INTERVAL_CYC >= (1 << TIMER_BITS)) begin
      $error("refresh interval out of range");
    end
  end

  always_comb begin
    st_next = st_reg;
    // the request sets even in the cycle it is taken, so no interval is lost
    if (taken) begin
      st_next.due = 1'b0;
    end
    if (st_reg.count == TIMER_BITS'(INTERVAL_CYC - 1)) begin
      st_next.count = '0;
      st_next.due = 1'b1;
    end else begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign due = st_reg.due;
endmodule : dwpr_refresh_timer

// file: verification/dwpr_props.sv
// pin-level assertions for the dram controller
`timescale 1ns/1ps
module dwpr_props import dwpr_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic req_ready, // request taken
  input wire logic rsp_valid, // read data strobe
  input wire logic sleep_req, // self refresh wanted
  input wire logic ready, // init done
  input wire logic row_strobe_n, // row strobe
  input wire logic column_strobe_n, // column strobe
  input wire logic write_strobe_n, // write strobe
  input wire logic refresh_request_n // refresh pin
);
  logic [15:0] ras_low_reg;
  logic [3:0] wake_reg;
  // counts row low time, cleared while row is high, and row cycles seen since reset, the latter capped to avoid wrap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ras_low_reg <= 16'h0000;
      wake_reg <= 4'h0;
    end else begin
      ras_low_reg <= row_strobe_n ? 16'h0000 : ras_low_reg + 16'h0001;
      if ($fell(row_strobe_n) && wake_reg != 4'hF) wake_reg <= wake_reg + 4'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  col_in_row_a: assert property ($fell(column_strobe_n) |-> !row_strobe_n)
    else $error("column strobe fell outside an open row");
  row_max_a: assert property (ras_low_reg <= 16'(ROW_ACTIVE_MAX_CYC))
    else $error("row strobe held active too long");
  row_lead_a: assert property ($fell(write_strobe_n) |-> !row_strobe_n [*4])
    else $error("row strobe ended too soon after write");
  col_lead_a: assert property ($fell(write_strobe_n) && !column_strobe_n |-> !column_strobe_n [*4])
    else $error("column strobe ended too soon after late write");
  col_pre_a: assert property ($rose(column_strobe_n) && !row_strobe_n |-> column_strobe_n [*5])
    else $error("column precharge too short in page");
  refresh_idle_a: assert property (!refresh_request_n |-> row_strobe_n && column_strobe_n)
    else $error("refresh pin low during a memory cycle");
  auto_pulse_a: assert property ($fell(refresh_request_n) && !sleep_req
    |-> ##[1:200] (refresh_request_n || sleep_req))
    else $error("auto refresh pulse too long");
  rsp_in_col_a: assert property (rsp_valid |-> !$past(column_strobe_n, 2))
    else $error("read data taken outside column strobe");
  wake_count_a: assert property ($rose(ready) |-> wake_reg >= 4'h8)
    else $error("ready before eight row cycles");
  take_ready_a: assert property (req_ready |-> ready)
    else $error("request taken before init done");
endmodule : dwpr_props
bind dwpr_controller dwpr_props u_props (.sys_clk, .rst_n, .req_ready, .rsp_valid, .sleep_req, .ready,
  .row_strobe_n, .column_strobe_n, .write_strobe_n, .refresh_request_n);

// file: verification/dwpr_dram_model.sv
// behavioural 64k x 1 dynamic ram with refresh pin
`timescale 1ns/1ps
module dwpr_dram_model import dwpr_pkg::*; #(
  parameter int ACCESS_NS = 60 // column access time, fastest grade
) (
  input wire logic sys_clk, // paces the refresh pin timer
  input wire logic row_strobe_n, // row strobe
  input wire logic column_strobe_n, // column strobe
  input wire logic write_strobe_n, // write strobe
  input wire logic refresh_request_n, // refresh pin
  input wire logic [ADDR_BITS-1:0] mem_addr, // multiplexed address
  input wire logic mem_din, // write data
  output logic mem_dout // read data
);
  logic cells [0:65535];
  logic [7:0] row_q, col_q;
  logic out_en, rd_bit;
  int low_cnt, refresh_count;
  logic [6:0] refresh_row;
  time ras_fall, ready_at;
  initial begin
    ras_fall = 0;
    ready_at = 0;
    foreach (cells[i]) cells[i] = 1'b0;
    out_en = 1'b0;
    rd_bit = 1'b0;
    low_cnt = 0;
    refresh_count = 0;
  end
  // address is taken just after the strobe so a same-edge address change lands first
  always @(negedge row_strobe_n) begin
    ras_fall = $time;
    #1;
    row_q = mem_addr;
  end
  always @(negedge column_strobe_n) begin
    #1;
    col_q = mem_addr;
    rd_bit = cells[{row_q, col_q}];
    // data turns valid only once both the row and the column access times have run
    ready_at = ras_fall + ROW_ACCESS_TIME_NS;
    if (ready_at < $time - 1 + ACCESS_NS) ready_at = $time - 1 + ACCESS_NS;
    if (!write_strobe_n) cells[{row_q, col_q}] = mem_din;
    else out_en <= #(ready_at - $time) 1'b1;
  end
  always @(negedge write_strobe_n) begin
    #1;
    if (!column_strobe_n) cells[{row_q, col_q}] = mem_din;
  end
  always @(posedge column_strobe_n) out_en <= 1'b0;
  // not driven: inverse of the last bit, never a stale copy
  assign mem_dout = out_en ? rd_bit : ~rd_bit;
  assign refresh_row = 7'(refresh_count);
  always @(posedge sys_clk) begin
    low_cnt <= refresh_request_n ? 0 : low_cnt + 1;
    if (refresh_request_n && low_cnt > 0) refresh_count <= refresh_count + 1;
    if (low_cnt > AUTO_REFRESH_PULSE_CYC && low_cnt % REFRESH_INTERVAL_CYC == 0)
      refresh_count <= refresh_count + 1;
  end
endmodule : dwpr_dram_model

// file: verification/dwpr_controller_bench.sv
// self-checking bench for the dram controller
`timescale 1ns/1ps
module dwpr_controller_bench;
  import dwpr_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_data = 1'b0, req_invert = 1'b0;
  logic sleep_req = 1'b0, req_ready, rsp_valid, rsp_data, ready, mem_din, mem_dout;
  logic row_strobe_n, column_strobe_n, write_strobe_n, refresh_request_n;
  logic [1:0] req_op = 2'h0;
  logic [7:0] req_row = 8'h00, req_col = 8'h00, mem_addr;
  logic shadow [0:65535];
  logic q [$];
  int errors = 0, num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  dwpr_controller #(.POWERUP_CYC(50), .INTERVAL_CYC(200), .USE_REFRESH_PIN(1'b1)) uut (.sys_clk, .rst_n,
    .req_valid, .req_ready, .req_op, .req_row, .req_col, .req_data, .req_invert, .sleep_req, .rsp_valid,
    .rsp_data, .ready, .row_strobe_n, .column_strobe_n, .write_strobe_n, .refresh_request_n, .mem_addr,
    .mem_din, .mem_dout);
  dwpr_dram_model u_mem (.sys_clk, .row_strobe_n, .column_strobe_n, .write_strobe_n, .refresh_request_n,
    .mem_addr, .mem_din, .mem_dout);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic start;
    int n;
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    check("ready", ready, 1'b1);
    if (ready !== 1'b1) results();
  endtask : start
  // leaves the request up so a page access can follow without a gap
  task automatic access(input logic [1:0] op, input logic [7:0] row, input logic [7:0] col, input logic d,
    input logic inv);
    int n;
    logic [15:0] a;
    a = {row, col};
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_op = op;
    req_row = row;
    req_col = col;
    req_data = d;
    req_invert = inv;
    n = 0;
    #1;
    while (req_ready !== 1'b1) begin
      @(negedge sys_clk);
      #1;
      n++;
      if (n > 3000) begin
        check("req_ready", req_ready, 1'b1);
        results();
      end
    end
    if (op == OP_READ || op == OP_READ_MODIFY_WRITE) q.push_back(shadow[a]);
    if (op == OP_EARLY_WRITE || op == OP_READ_WHILE_WRITE) shadow[a] = d;
    if (op == OP_READ_MODIFY_WRITE) shadow[a] = shadow[a] ^ inv;
    @(posedge sys_clk);
  endtask : access
  task automatic release_req;
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask : release_req
  // a reset would drop reads still in flight, so every owed response is collected first
  task automatic drain;
    int n;
    n = 0;
    while (q.size() != 0 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    check("responses owed", q.size(), 0);
  endtask : drain
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) check("unexpected read data", 1'b1, 1'b0);
      else check("read data", rsp_data, q.pop_front());
    end
  end
  initial begin
    int n;
    foreach (shadow[i]) shadow[i] = 1'b0;
    void'($urandom(3));
    start();
    // two boundary rows and columns give page hits, misses and rereads of the same cells
    for (int i = 0; i < 64; i++)
      access(2'(i), $urandom_range(1) ? 8'hFF : 8'h00, $urandom_range(1) ? 8'hFF : 8'h00,
        1'($urandom), 1'($urandom));
    release_req();
    n = u_mem.refresh_count;
    repeat (900) @(negedge sys_clk);
    check("pin refreshes", (u_mem.refresh_count - n) >= 4, 1'b1);
    sleep_req = 1'b1;
    req_valid = 1'b1;
    repeat (300) @(negedge sys_clk);
    check("self refresh pin", refresh_request_n, 1'b0);
    check("request refused asleep", req_ready, 1'b0);
    req_valid = 1'b0;
    sleep_req = 1'b0;
    for (int i = 0; i < 4; i++) access(OP_READ, i[1] ? 8'hFF : 8'h00, i[0] ? 8'hFF : 8'h00, 1'b0, 1'b0);
    release_req();
    drain();
    start();
    for (int i = 0; i < 4; i++) access(OP_READ, i[1] ? 8'hFF : 8'h00, i[0] ? 8'hFF : 8'h00, 1'b0, 1'b0);
    release_req();
    drain();
    results();
  end
endmodule : dwpr_controller_bench
